/* ctlm_defs.vh */
// constants, codes and reset values of the current and temperature limit monitor
//
// What this block does
// - per-channel sense gain word at 0x38 in milliohms, reset 0xbb9a
// - per-channel gain temperature coefficient at 0xf6, signed ppm, reset 3900
// - sense gain scaled by one plus coefficient times temperature less 27
// - adjusted gain used for output and input readings and overcurrent limits
// - input current above 0x5d limit sets other, input, iin warn, alert
// - telemetry limit checks may take up to 120 ms to show
// - peak fault limit at 0x46 rounds up to next discrete step, top step if above all steps
// - range bit clear: steps 25 to 50 mV over sense gain
// - range bit set: steps 37.5 to 75 mV over sense gain
// - fault limit checks peak current; output reading reports average current
// - peak fault threshold recomputed with temperature-adjusted sense gain
// - output fault limit ignored while output ramps up or down
// - average output current above 0x4a sets none-above, iout, warn, alert
// - external temperature slope N times 2^-14, N 8192 to 32767
// - temperature offset at 0xf9 added to a -273.15 base
// - overtemperature fault when temperature exceeds 0x4f limit, default 100
// - per-channel overtemperature warn 0x51 and undertemperature fault 0x53
// - every limit and calibration is a two-byte word, linear format except raw integer coefficient and slope
// - overtemperature warn sets temperature bit, warn bit and alert
`ifndef CTLM_DEFS_VH
`define CTLM_DEFS_VH

// command codes
`define CTLM_CMD_PAGE        8'h00
`define CTLM_CMD_CLEAR       8'h03
`define CTLM_CMD_GAIN        8'h38
`define CTLM_CMD_OCF         8'h46
`define CTLM_CMD_OCW         8'h4a
`define CTLM_CMD_OTF         8'h4f
`define CTLM_CMD_OTW         8'h51
`define CTLM_CMD_UTF         8'h53
`define CTLM_CMD_IIN         8'h5d
`define CTLM_CMD_STAT_BYTE   8'h78
`define CTLM_CMD_STAT_WORD   8'h79
`define CTLM_CMD_STAT_IOUT   8'h7b
`define CTLM_CMD_STAT_INPUT  8'h7c
`define CTLM_CMD_STAT_TEMP   8'h7d
`define CTLM_CMD_READ_IIN    8'h89
`define CTLM_CMD_READ_IOUT   8'h8c
`define CTLM_CMD_MASK        8'hd0
`define CTLM_CMD_TC          8'hf6
`define CTLM_CMD_SLOPE       8'hf8
`define CTLM_CMD_TOFF        8'hf9

// reset values
`define CTLM_RST_GAIN        16'hbb9a
`define CTLM_RST_OCF         16'hdbb8
`define CTLM_RST_OCW         16'hda80
`define CTLM_RST_OTF         16'heb20
`define CTLM_RST_OTW         16'heaa8
`define CTLM_RST_UTF         16'he580
`define CTLM_RST_IIN         16'hd280
`define CTLM_RST_TC          16'h0f3c
`define CTLM_RST_SLOPE       16'h4000
`define CTLM_RST_TOFF        16'h8000
`define CTLM_RST_MASK        16'h0000
`define CTLM_SLOPE_MIN       16'h2000
`define CTLM_SLOPE_MAX       16'h7fff
`define CTLM_SLOPE_SHIFT     14

// arithmetic constants, temperatures in Q8
`define CTLM_NOM_TEMP_Q8     64'sh1b00
`define CTLM_KELVIN_Q8       64'sh11126
`define CTLM_PPM_Q8          64'sh0f424000
`define CTLM_UV_PER_MV       64'sh3e8
`define CTLM_STEP_UV         64'sh64
`define CTLM_RD_SCALE        64'sh1000
`define CTLM_RD_EXP          5'h1c
`define CTLM_Q8_FRAC         6'sh08

// status flag positions per channel
`define CTLM_FLG_IOW         0
`define CTLM_FLG_OCF         1
`define CTLM_FLG_OTF         2
`define CTLM_FLG_OTW         3
`define CTLM_FLG_UTF         4
`define CTLM_FLG_IIN         5

`endif

/* ctlm_host_model.sv */
// management bus host model: start, stop, word reads and writes
module ctlm_host_model (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime Q = 31.25;
  logic [6:0] addr = 7'h40;
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic xbit(input logic b, output logic r);
    sda_low_out = ~b;
    #Q scl_out = 1'b1;
    #Q r = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic xbyte(input logic [7:0] b, input logic nack, output logic [7:0] r,
                       output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) xbit(b[i], r[i]);
    xbit(nack, a);
    ack = ~a;
  endtask
  task automatic start;
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b1;
    #Q scl_out = 1'b0;
    #Q;
  endtask
  task automatic stop;
    sda_low_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_low_out = 1'b0;
    #(4*Q);
  endtask
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, input int n,
                            output logic ok);
    logic [7:0] r;
    logic       a;
    start;
    xbyte({addr, 1'b0}, 1'b1, r, ok);
    xbyte(cmd, 1'b1, r, a);
    for (int i = 0; i < n; i++) xbyte(d[8*i +: 8], 1'b1, r, a);
    stop;
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d);
    logic a;
    start;
    xbyte({addr, 1'b0}, 1'b1, d[7:0], a);
    xbyte(cmd, 1'b1, d[7:0], a);
    start;
    xbyte({addr, 1'b1}, 1'b1, d[7:0], a);
    xbyte(8'hff, 1'b0, d[7:0], a);
    xbyte(8'hff, 1'b1, d[15:8], a);
    stop;
  endtask
endmodule // ctlm_host_model

/* ctlm_monitor.v */
// two-channel current and temperature calibration, limits and status
`include "ctlm_defs.vh"
module ctlm_monitor #(
  parameter [6:0] DEV_ADDR = 7'h40
) (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  input  wire        pmbus_scl_in,
  input  wire        pmbus_sda_in,
  input  wire [1:0]  pwm_mode_range_in,
  input  wire [1:0]  turn_on_ramp_in,
  input  wire [1:0]  turn_off_ramp_in,
  input  wire        adc_valid_in,
  input  wire [47:0] adc_iout_uv_in,
  input  wire [47:0] adc_ipeak_uv_in,
  input  wire [23:0] adc_iin_uv_in,
  input  wire [47:0] adc_temp_k_in,
  output reg         pmbus_sda_out,
  output reg         pmbus_sda_oe_out,
  output reg         alert_n_out,
  output reg  [1:0]  oc_fault_out
);
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // linear word to signed Q8
  function signed [63:0] l11_q8(input [15:0] w);
    reg signed [63:0] m;
    reg signed [5:0]  s;
    begin
      m = {{53{w[10]}}, w[10:0]};
      s = $signed({w[15], w[15:11]}) + `CTLM_Q8_FRAC;
      if (s[5])
        l11_q8 = m >>> (-s);
      else
        l11_q8 = m <<< s;
    end
  endfunction

  // storage slot of a command, 5'h1f when none
  function [4:0] cfg_addr(input [7:0] cmd, input pg);
    begin
      if (cmd == `CTLM_CMD_GAIN)       cfg_addr = {4'h0, pg};
      else if (cmd == `CTLM_CMD_OCF)   cfg_addr = {4'h1, pg};
      else if (cmd == `CTLM_CMD_OCW)   cfg_addr = {4'h2, pg};
      else if (cmd == `CTLM_CMD_OTF)   cfg_addr = {4'h3, pg};
      else if (cmd == `CTLM_CMD_OTW)   cfg_addr = {4'h4, pg};
      else if (cmd == `CTLM_CMD_UTF)   cfg_addr = {4'h5, pg};
      else if (cmd == `CTLM_CMD_TC)    cfg_addr = {4'h6, pg};
      else if (cmd == `CTLM_CMD_SLOPE) cfg_addr = {4'h7, pg};
      else if (cmd == `CTLM_CMD_TOFF)  cfg_addr = {4'h8, pg};
      else if (cmd == `CTLM_CMD_IIN)   cfg_addr = 5'h12;
      else if (cmd == `CTLM_CMD_MASK)  cfg_addr = 5'h13;
      else                             cfg_addr = 5'h1f;
    end
  endfunction

  function [15:0] cfg_rst(input [4:0] a);
    begin
      case (a[4:1])
        4'h0:    cfg_rst = `CTLM_RST_GAIN;
        4'h1:    cfg_rst = `CTLM_RST_OCF;
        4'h2:    cfg_rst = `CTLM_RST_OCW;
        4'h3:    cfg_rst = `CTLM_RST_OTF;
        4'h4:    cfg_rst = `CTLM_RST_OTW;
        4'h5:    cfg_rst = `CTLM_RST_UTF;
        4'h6:    cfg_rst = `CTLM_RST_TC;
        4'h7:    cfg_rst = `CTLM_RST_SLOPE;
        4'h8:    cfg_rst = `CTLM_RST_TOFF;
        default: cfg_rst = a[0] ? `CTLM_RST_MASK : `CTLM_RST_IIN;
      endcase
    end
  endfunction

  // fault steps in tenths of a millivolt of sense voltage
  function [9:0] step_tab(input hi, input [2:0] k);
    begin
      case ({hi, k})
        4'h0:    step_tab = 10'h0fa;
        4'h1:    step_tab = 10'h11e;
        4'h2:    step_tab = 10'h141;
        4'h3:    step_tab = 10'h165;
        4'h4:    step_tab = 10'h189;
        4'h5:    step_tab = 10'h1ad;
        4'h6:    step_tab = 10'h1d0;
        4'h7:    step_tab = 10'h1f4;
        4'h8:    step_tab = 10'h177;
        4'h9:    step_tab = 10'h1ad;
        4'ha:    step_tab = 10'h1e2;
        4'hb:    step_tab = 10'h218;
        4'hc:    step_tab = 10'h24d;
        4'hd:    step_tab = 10'h283;
        4'he:    step_tab = 10'h2b8;
        default: step_tab = 10'h2ee;
      endcase
    end
  endfunction

  // smallest step at or above the request, top step if none
  function signed [63:0] step_pick(input hi, input signed [63:0] req);
    integer           k;
    reg signed [63:0] s;
    begin
      step_pick = $signed({54'h0, step_tab(hi, 3'h7)}) * `CTLM_STEP_UV;
      for (k = 7; k >= 0; k = k - 1)
      begin
        s = $signed({54'h0, step_tab(hi, k[2:0])}) * `CTLM_STEP_UV;
        if (s >= req)
          step_pick = s;
      end
    end
  endfunction

  // -------------------------------------------------------------
  // serial link and word transactions
  // -------------------------------------------------------------
  reg  [15:0] cfg [0:19];
  reg         page;
  reg  [7:0]  cmd;
  reg  [1:0]  cnt;
  reg  [7:0]  lo;
  reg  [7:0]  hi;
  reg  [15:0] rdw;
  reg  [15:0] next_rdw;
  reg         tx_sel;
  reg  [11:0] flg;
  reg  [21:0] rd_iout;
  reg  [10:0] rd_iin;
  wire        sda_oe;
  wire        addr_wr;
  wire        addr_rd;
  wire        rx_valid;
  wire [7:0]  rx_byte;
  wire        tx_adv;
  wire        stop;
  wire [4:0]  wa = cfg_addr(cmd, page);
  wire        word_wr = stop && cnt == 2'h3 && wa != 5'h1f;
  wire        slope_ok = ({hi, lo} >= `CTLM_SLOPE_MIN) && ({hi, lo} <= `CTLM_SLOPE_MAX);
  wire        clr = stop && cnt == 2'h1 && cmd == `CTLM_CMD_CLEAR;
  wire [5:0]  pf = page ? flg[11:6] : flg[5:0];
  wire        iin_f = flg[`CTLM_FLG_IIN];
  wire [7:0]  st_byte;
  wire [11:0] ev;

  ctlm_pmbus_link u_link (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_n_in),
    .dev_addr_in  (DEV_ADDR),
    .scl_in       (pmbus_scl_in),
    .sda_in       (pmbus_sda_in),
    .tx_byte_in   (tx_sel ? rdw[15:8] : rdw[7:0]),
    .sda_oe_out   (sda_oe),
    .addr_wr_out  (addr_wr),
    .addr_rd_out  (addr_rd),
    .rx_valid_out (rx_valid),
    .rx_byte_out  (rx_byte),
    .tx_adv_out   (tx_adv),
    .stop_out     (stop)
  );

  always @(posedge clk_sys_in)
  begin : xfer
    integer i;
    if (!rst_n_in)
    begin
      for (i = 0; i < 20; i = i + 1)
        cfg[i] <= cfg_rst(i[4:0]);
      page   <= 1'b0;
      cmd    <= 8'h00;
      cnt    <= 2'h0;
      lo     <= 8'h00;
      hi     <= 8'h00;
      rdw    <= 16'h0000;
      tx_sel <= 1'b0;
    end
    else
    begin
      if (addr_wr)
        cnt <= 2'h0;
      else if (rx_valid)
      begin
        if (cnt == 2'h0)
          cmd <= rx_byte;
        else if (cnt == 2'h1)
          lo <= rx_byte;
        else if (cnt == 2'h2)
          hi <= rx_byte;
        if (cnt != 2'h3)
          cnt <= cnt + 2'h1;
      end
      else if (stop)
        cnt <= 2'h0;
      // word writes, slope refuses values outside its range
      if (word_wr && (cmd != `CTLM_CMD_SLOPE || slope_ok))
        cfg[wa] <= {hi, lo};
      if (stop && cnt == 2'h2 && cmd == `CTLM_CMD_PAGE && lo[7:1] == 7'h00)
        page <= lo[0];
      if (addr_rd)
      begin
        rdw    <= next_rdw;
        tx_sel <= 1'b0;
      end
      else if (tx_adv)
        tx_sel <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // status views and read data
  // -------------------------------------------------------------
  assign st_byte = {3'h0, pf[`CTLM_FLG_OCF], 1'b0,
                    pf[`CTLM_FLG_OTF] | pf[`CTLM_FLG_OTW] | pf[`CTLM_FLG_UTF],
                    iin_f, pf[`CTLM_FLG_IOW]};

  always @*
  begin
    next_rdw = 16'h0000;
    if (wa != 5'h1f)
      next_rdw = cfg[wa];
    else if (cmd == `CTLM_CMD_PAGE)
      next_rdw = {15'h0000, page};
    else if (cmd == `CTLM_CMD_STAT_BYTE)
      next_rdw = {8'h00, st_byte};
    else if (cmd == `CTLM_CMD_STAT_WORD)
      next_rdw = {1'b0, pf[`CTLM_FLG_IOW] | pf[`CTLM_FLG_OCF], iin_f, 5'h00, st_byte};
    else if (cmd == `CTLM_CMD_STAT_IOUT)
      next_rdw = {8'h00, pf[`CTLM_FLG_OCF], 1'b0, pf[`CTLM_FLG_IOW], 5'h00};
    else if (cmd == `CTLM_CMD_STAT_INPUT)
      next_rdw = {8'h00, 6'h00, iin_f, 1'b0};
    else if (cmd == `CTLM_CMD_STAT_TEMP)
      next_rdw = {8'h00, pf[`CTLM_FLG_OTF], pf[`CTLM_FLG_OTW], 1'b0,
                  pf[`CTLM_FLG_UTF], 4'h0};
    else if (cmd == `CTLM_CMD_READ_IOUT)
      next_rdw = {`CTLM_RD_EXP, page ? rd_iout[21:11] : rd_iout[10:0]};
    else if (cmd == `CTLM_CMD_READ_IIN)
      next_rdw = {`CTLM_RD_EXP, rd_iin};
  end

  // -------------------------------------------------------------
  // per-channel calibration and limit checks
  // -------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : ch
      wire signed [63:0] gain  = l11_q8(cfg[c]);
      wire [15:0]        tcw   = cfg[12 + c];
      wire [15:0]        slw   = cfg[14 + c];
      wire signed [63:0] tc    = $signed({{48{tcw[15]}}, tcw});
      wire signed [63:0] slope = $signed({48'h0, slw});
      wire signed [63:0] tk    = $signed({40'h0, adc_temp_k_in[c*24 +: 24]});
      wire signed [63:0] temp  = ((tk * slope) >>> `CTLM_SLOPE_SHIFT)
                                 + l11_q8(cfg[16 + c]) - `CTLM_KELVIN_Q8;
      wire signed [63:0] corr  = tc * (temp - `CTLM_NOM_TEMP_Q8);
      wire signed [63:0] geff  = gain + (gain * corr) / `CTLM_PPM_Q8;
      wire signed [63:0] ocw_uv = (l11_q8(cfg[4 + c]) * geff * `CTLM_UV_PER_MV) >>> 16;
      wire signed [63:0] ocf_uv = (l11_q8(cfg[2 + c]) * geff * `CTLM_UV_PER_MV) >>> 16;
      wire signed [63:0] step  = step_pick(pwm_mode_range_in[c], ocf_uv);
      wire signed [63:0] iavg  = $signed({{40{adc_iout_uv_in[c*24+23]}}, adc_iout_uv_in[c*24 +: 24]});
      wire signed [63:0] ipk   = $signed({{40{adc_ipeak_uv_in[c*24+23]}}, adc_ipeak_uv_in[c*24 +: 24]});
      wire               ramp  = turn_on_ramp_in[c] | turn_off_ramp_in[c];
      wire signed [63:0] rd    = (geff > 64'sh0) ?
                                 (iavg * `CTLM_RD_SCALE) / (geff * `CTLM_UV_PER_MV) : 64'sh0;
      assign ev[c*6 + `CTLM_FLG_IOW] = iavg > ocw_uv;
      assign ev[c*6 + `CTLM_FLG_OCF] = (ipk > step) && !ramp;
      assign ev[c*6 + `CTLM_FLG_OTF] = temp > l11_q8(cfg[6 + c]);
      assign ev[c*6 + `CTLM_FLG_OTW] = temp > l11_q8(cfg[8 + c]);
      assign ev[c*6 + `CTLM_FLG_UTF] = temp < l11_q8(cfg[10 + c]);
    end
  endgenerate

  wire signed [63:0] iin_uv  = $signed({{40{adc_iin_uv_in[23]}}, adc_iin_uv_in});
  wire signed [63:0] iin_thr = (l11_q8(cfg[18]) * ch[0].geff * `CTLM_UV_PER_MV) >>> 16;
  wire signed [63:0] iin_rd  = (ch[0].geff > 64'sh0) ?
                               (iin_uv * `CTLM_RD_SCALE) / (ch[0].geff * `CTLM_UV_PER_MV) : 64'sh0;
  assign ev[`CTLM_FLG_IIN]     = iin_uv > iin_thr;
  assign ev[6 + `CTLM_FLG_IIN] = 1'b0;

  // -------------------------------------------------------------
  // sticky flags, alert and outputs
  // -------------------------------------------------------------
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      flg              <= 12'h000;
      rd_iout          <= 22'h000000;
      rd_iin           <= 11'h000;
      oc_fault_out     <= 2'h0;
      alert_n_out      <= 1'b1;
      pmbus_sda_out    <= 1'b0;
      pmbus_sda_oe_out <= 1'b0;
    end
    else
    begin
      // new events win over a clear in the same cycle
      flg <= (flg & ~{12{clr}}) | (adc_valid_in ? ev : 12'h000);
      if (adc_valid_in)
      begin
        rd_iout      <= {ch[1].rd[10:0], ch[0].rd[10:0]};
        rd_iin       <= iin_rd[10:0];
        oc_fault_out <= {ev[6 + `CTLM_FLG_OCF], ev[`CTLM_FLG_OCF]};
      end
      alert_n_out      <= ~|(flg & ~{cfg[19][5:0], cfg[19][5:0]});
      pmbus_sda_out    <= 1'b0;
      pmbus_sda_oe_out <= sda_oe;
    end
  end
endmodule // ctlm_monitor

/* ctlm_monitor_props.sv */
// assertion checker for the limit monitor ports
module ctlm_monitor_props (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        pmbus_sda_in,
  input wire logic [1:0]  turn_on_ramp_in,
  input wire logic [1:0]  turn_off_ramp_in,
  input wire logic        adc_valid_in,
  input wire logic [47:0] adc_ipeak_uv_in,
  input wire logic        alert_n_out,
  input wire logic [1:0]  oc_fault_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // --------
  // peak fault
  // --------
  a_ocf_ramp_on: assert property (adc_valid_in && turn_on_ramp_in[0] |=> !oc_fault_out[0])
    else $error("peak fault during turn-on ramp");
  a_ocf_ramp_off: assert property (adc_valid_in && turn_off_ramp_in[1] |=> !oc_fault_out[1])
    else $error("peak fault during turn-off ramp");
  a_ocf_hold: assert property (!adc_valid_in |=> $stable(oc_fault_out))
    else $error("peak fault moved without sample");
  a_ocf_top_step: assert property (adc_valid_in && !turn_on_ramp_in[0] && !turn_off_ramp_in[0]
    && $signed(adc_ipeak_uv_in[23:0]) > 75000 |=> oc_fault_out[0])
    else $error("peak above top step not flagged");
  a_ocf_min_step: assert property (adc_valid_in && $signed(adc_ipeak_uv_in[23:0]) <= 25000
    |=> !oc_fault_out[0])
    else $error("peak below lowest step flagged");
  a_ocf_cause: assert property ($rose(oc_fault_out[0]) |-> $past(adc_valid_in))
    else $error("peak fault rose without sample");
  // --------
  // alert
  // --------
  a_alert_sticky: assert property (pmbus_sda_in[*8] ##0 !alert_n_out |=> !alert_n_out)
    else $error("alert released without host clear");
  a_alert_cause: assert property (pmbus_sda_in[*8] ##0 $fell(alert_n_out) |-> $past(adc_valid_in, 2))
    else $error("alert fell without sample");
  c_fault: cover property (adc_valid_in ##1 oc_fault_out[0]);
  c_alert: cover property ($fell(alert_n_out));
  c_clear: cover property ($rose(alert_n_out));
endmodule // ctlm_monitor_props

/* ctlm_pmbus_link.v */
// serial byte engine of the management link: start, stop, address, ack
module ctlm_pmbus_link (
  input  wire       clk_sys_in,
  input  wire       rst_n_in,
  input  wire [6:0] dev_addr_in,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire [7:0] tx_byte_in,
  output reg        sda_oe_out,
  output reg        addr_wr_out,
  output reg        addr_rd_out,
  output reg        rx_valid_out,
  output reg  [7:0] rx_byte_out,
  output reg        tx_adv_out,
  output reg        stop_out
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_RX   = 5'b00010;
  localparam ST_RACK = 5'b00100;
  localparam ST_TX   = 5'b01000;
  localparam ST_TACK = 5'b10000;

  reg       scl_m;
  reg       scl_s;
  reg       scl_q;
  reg       sda_m;
  reg       sda_s;
  reg       sda_q;
  reg [4:0] state;
  reg [3:0] bits;
  reg [7:0] shreg;
  reg       addr_ph;
  reg       rd;

  wire start_c = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c  = scl_s & scl_q & ~sda_q & sda_s;
  wire rise    = scl_s & ~scl_q;
  wire fall    = ~scl_s & scl_q;

  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      {scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3f;
      state        <= ST_IDLE;
      bits         <= 4'h0;
      shreg        <= 8'h00;
      addr_ph      <= 1'b0;
      rd           <= 1'b0;
      sda_oe_out   <= 1'b0;
      addr_wr_out  <= 1'b0;
      addr_rd_out  <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_byte_out  <= 8'h00;
      tx_adv_out   <= 1'b0;
      stop_out     <= 1'b0;
    end
    else
    begin
      scl_m        <= scl_in;
      scl_s        <= scl_m;
      scl_q        <= scl_s;
      sda_m        <= sda_in;
      sda_s        <= sda_m;
      sda_q        <= sda_s;
      addr_wr_out  <= 1'b0;
      addr_rd_out  <= 1'b0;
      rx_valid_out <= 1'b0;
      tx_adv_out   <= 1'b0;
      stop_out     <= stop_c;
      if (stop_c)
      begin
        state      <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end
      else if (start_c)
      begin
        state      <= ST_RX;
        bits       <= 4'h0;
        addr_ph    <= 1'b1;
        rd         <= 1'b0;
        sda_oe_out <= 1'b0;
      end
      else
      begin
        case (state)
          ST_RX:
            if (rise)
            begin
              shreg <= {shreg[6:0], sda_s};
              bits  <= bits + 4'h1;
            end
            else if (fall && bits == 4'h8)
            begin
              bits <= 4'h0;
              if (!addr_ph)
              begin
                rx_valid_out <= 1'b1;
                rx_byte_out  <= shreg;
                sda_oe_out   <= 1'b1;
                state        <= ST_RACK;
              end
              else if (shreg[7:1] == dev_addr_in)
              begin
                rd          <= shreg[0];
                addr_wr_out <= ~shreg[0];
                addr_rd_out <= shreg[0];
                sda_oe_out  <= 1'b1;
                state       <= ST_RACK;
              end
              else
                state <= ST_IDLE;
            end
          ST_RACK:
            if (fall)
            begin
              addr_ph <= 1'b0;
              if (rd)
              begin
                shreg      <= tx_byte_in;
                sda_oe_out <= ~tx_byte_in[7];
                state      <= ST_TX;
              end
              else
              begin
                sda_oe_out <= 1'b0;
                state      <= ST_RX;
              end
            end
          ST_TX:
            if (fall)
            begin
              if (bits == 4'h7)
              begin
                sda_oe_out <= 1'b0;
                bits       <= 4'h0;
                state      <= ST_TACK;
              end
              else
              begin
                shreg      <= {shreg[6:0], 1'b0};
                sda_oe_out <= ~shreg[6];
                bits       <= bits + 4'h1;
              end
            end
          ST_TACK:
            if (rise)
            begin
              if (sda_s)
                state <= ST_IDLE;
              else
                tx_adv_out <= 1'b1;
            end
            else if (fall)
            begin
              shreg      <= tx_byte_in;
              sda_oe_out <= ~tx_byte_in[7];
              state      <= ST_TX;
            end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // ctlm_pmbus_link

/* tb_top.sv */
// self-checking bench of the limit monitor
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T0 = 69926;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [1:0]  range = '0, ron = '0, roff = '0, ocf;
  logic        adc_valid = 1'b0;
  logic [23:0] io = '0, pk = '0, ii = '0, tk = 24'(T0 + 27*256);
  logic        scl, host_low, dut_oe, alert_n, ok;
  wire         sda = ~(host_low | dut_oe);
  int          n_errors = 0, check_count = 0;
  logic [15:0] d;
  ctlm_monitor i_ctlm_monitor (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .pmbus_scl_in(scl), .pmbus_sda_in(sda), .pwm_mode_range_in(range),
    .turn_on_ramp_in(ron), .turn_off_ramp_in(roff), .adc_valid_in(adc_valid),
    .adc_iout_uv_in({io, io}), .adc_ipeak_uv_in({pk, pk}), .adc_iin_uv_in(ii),
    .adc_temp_k_in({tk, tk}), .pmbus_sda_out(), .pmbus_sda_oe_out(dut_oe),
    .alert_n_out(alert_n), .oc_fault_out(ocf));
  ctlm_host_model i_ctlm_host_model (.sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  initial
  begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // --------
  // helpers
  // --------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] c);
    i_ctlm_host_model.read_word(c, d);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input int n = 2);
    i_ctlm_host_model.write_word(c, v, n, ok);
  endtask
  task automatic do_reset;
    @(posedge clk_sys_in) #1 rst_n_in = 1'b0;
    repeat (16) @(posedge clk_sys_in) #1;
    rst_n_in = 1'b1;
    repeat (4) @(posedge clk_sys_in) #1;
    chk("alert idle", 16'h1, alert_n);
  endtask
  task automatic adc(input int vio, input int vpk, input int vii, input int vt);
    @(posedge clk_sys_in) #1;
    io = 24'(vio);
    pk = 24'(vpk);
    ii = 24'(vii);
    tk = 24'(T0 + vt * 256);
    adc_valid = 1'b1;
    @(posedge clk_sys_in) #1;
    adc_valid = 1'b0;
    repeat (2) @(posedge clk_sys_in) #1;
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_regs;
    logic [7:0]  c [10] = '{8'h38, 8'h46, 8'h4a, 8'h4f, 8'h51, 8'h53, 8'h5d, 8'hf6, 8'hf8, 8'hf9};
    logic [15:0] v [10] = '{16'hbb9a, 16'hdbb8, 16'hda80, 16'heb20, 16'heaa8, 16'he580,
                            16'hd280, 16'h0f3c, 16'h4000, 16'h8000};
    for (int i = 0; i < 10; i++)
    begin
      rd(c[i]);
      chk("reset value", v[i], d);
      wr(c[i], 16'h2345);
      rd(c[i]);
      chk("readback", 16'h2345, d);
    end
    wr(8'hf8, 16'h1fff);
    rd(8'hf8);
    chk("slope below range", 16'h2345, d);
    rd(8'he0);
    chk("unmapped read", 16'h0, d);
    i_ctlm_host_model.addr = 7'h41;
    wr(8'h38, 16'h0);
    chk("foreign address ack", 16'h0, ok);
    i_ctlm_host_model.addr = 7'h40;
  endtask
  task automatic t_warn;
    adc(36000, 0, 0, 27);
    chk("alert at limit", 16'h1, alert_n);
    adc(36100, 0, 0, 27);
    chk("alert", 16'h0, alert_n);
    rd(8'h8c);
    chk("rd iout", 16'he140, d);
    adc(0, 0, 0, 27);
    chk("alert sticky", 16'h0, alert_n);
    rd(8'h78);
    chk("byte none above", 16'h1, d[0]);
    rd(8'h79);
    chk("word iout", 16'h1, d[14]);
    rd(8'h7b);
    chk("iout warn", 16'h1, d[5]);
    wr(8'h03, 16'h0, 0);
    chk("alert cleared", 16'h1, alert_n);
    wr(8'hd0, 16'h0001);
    adc(36100, 0, 0, 27);
    chk("alert masked", 16'h1, alert_n);
    wr(8'hd0, 16'h0000);
    wr(8'h03, 16'h0, 0);
    adc(37000, 0, 0, 37);
    chk("alert warm below", 16'h1, alert_n);
    adc(37800, 0, 0, 37);
    chk("alert warm above", 16'h0, alert_n);
    wr(8'h03, 16'h0, 0);
  endtask
  task automatic t_iin;
    adc(0, 0, 17900, 27);
    chk("iin quiet", 16'h1, alert_n);
    adc(0, 0, 18100, 27);
    chk("iin alert", 16'h0, alert_n);
    rd(8'h89);
    chk("rd iin", 16'he0a0, d);
    rd(8'h7c);
    chk("input warn", 16'h1, d[1]);
    rd(8'h79);
    chk("byte other, word input", 16'h3, {d[13], d[1]});
    wr(8'h03, 16'h0, 0);
  endtask
  task automatic t_peak;
    adc(0, 50000, 0, 27);
    chk("low top step", 16'h0, ocf);
    adc(0, 50001, 0, 27);
    chk("low above top", 16'h3, ocf);
    range = 2'b11;
    adc(0, 53600, 0, 27);
    chk("high step", 16'h0, ocf);
    adc(0, 53601, 0, 27);
    chk("high above step", 16'h3, ocf);
    adc(0, 60000, 0, 77);
    chk("hot step", 16'h0, ocf);
    adc(0, 64301, 0, 77);
    chk("hot above step", 16'h3, ocf);
    rd(8'h7b);
    chk("iout fault bit", 16'h1, d[7]);
    ron = 2'b01;
    roff = 2'b10;
    adc(0, 80000, 0, 27);
    chk("ramping", 16'h0, ocf);
    ron = 2'b00;
    roff = 2'b00;
    adc(0, 80000, 0, 27);
    chk("steady", 16'h3, ocf);
    adc(60000, -5, 0, 27);
    chk("average only", 16'h0, ocf);
    wr(8'h03, 16'h0, 0);
  endtask
  task automatic t_temp;
    adc(0, 0, 0, 90);
    rd(8'h7d);
    chk("ot warn", 16'h2, {d[7:6], d[4]});
    rd(8'h78);
    chk("byte temperature", 16'h1, d[2]);
    wr(8'h03, 16'h0, 0);
    adc(0, 0, 0, 101);
    rd(8'h7d);
    chk("ot fault", 16'h6, {d[7:6], d[4]});
    wr(8'h03, 16'h0, 0);
    adc(0, 0, 0, -41);
    rd(8'h7d);
    chk("ut fault", 16'h1, {d[7:6], d[4]});
    wr(8'h03, 16'h0, 0);
    wr(8'hf9, 16'hd280);
    adc(0, 0, 0, 80);
    rd(8'h7d);
    chk("offset warn", 16'h2, {d[7:6], d[4]});
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    do_reset;
    t_regs;
    do_reset;
    t_warn;
    t_iin;
    t_peak;
    t_temp;
    conclude;
  end
  initial
  begin
    repeat (100000) @(posedge clk_sys_in);
    n_errors++;
    conclude;
  end
endmodule // tb_top
bind ctlm_monitor ctlm_monitor_props i_ctlm_monitor_props (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .pmbus_sda_in(pmbus_sda_in), .turn_on_ramp_in(turn_on_ramp_in),
  .turn_off_ramp_in(turn_off_ramp_in), .adc_valid_in(adc_valid_in),
  .adc_ipeak_uv_in(adc_ipeak_uv_in), .alert_n_out(alert_n_out), .oc_fault_out(oc_fault_out));
